// ### hw/ebl_pkg.sv
// Purpose: shared constants and types for the endian byte-lane steering block
// Assumes: 32-bit data path, four byte lanes
// Notes: widths fixed

package ebl_pkg;

	localparam int unsigned LANES = 4;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned BIG_ENDIAN_BIT = 7;
	localparam logic [3:0] ENABLE_NONE = 4'h0;
	localparam logic [3:0] ENABLE_ALL = 4'hf;
	localparam logic [3:0] ENABLE_LOW_HALF = 4'h3;
	localparam logic [3:0] ENABLE_HIGH_HALF = 4'hc;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;

	typedef enum logic [1:0]
	{
		EBL_SIZE_BYTE,
		EBL_SIZE_HALF,
		EBL_SIZE_WORD,
		EBL_SIZE_BAD
	} ebl_size_t;

	typedef enum logic
	{
		EBL_ST_IDLE,
		EBL_ST_READ_WAIT
	} ebl_state_t;

endpackage

// ### hw/ebl_lane_steer.sv
// Purpose: byte-enable generation and lane steering for one access
// Assumes: address low bits and size are stable while used
// Notes: purely combinational

`timescale 1ns/1ps
`default_nettype none

module ebl_lane_steer
(
	// access description
	input wire ebl_pkg::ebl_size_t size,
	input wire logic [1:0] byte_addr,
	input wire logic big_endian,
	// data
	input wire logic [31:0] store_value,
	input wire logic [31:0] bus_read_data,
	// results
	output logic [3:0] lane_enable,
	output logic [31:0] lane_write_data,
	output logic [31:0] steered_read_data,
	output logic aligned
);

	// lane index for a byte, reversed when big-endian
	function automatic logic [1:0] phys_lane(input logic [1:0] n, input logic be);
		phys_lane = be ? (2'h3 - n) : n;
	endfunction

	wire logic [1:0] byte_lane;
	wire logic half_upper;
	wire logic [3:0] byte_enable;
	wire logic [3:0] half_enable;
	wire logic [7:0] mux4_out;
	wire logic [15:0] mux2_out;

	assign byte_lane = phys_lane(byte_addr, big_endian); // see RULE5
	assign byte_enable = 4'h1 << byte_lane; // see RULE12
	// halfword pair swapped for big-endian
	assign half_upper = byte_addr[1] ^ big_endian; // see RULE7
	assign half_enable = half_upper ? ebl_pkg::ENABLE_HIGH_HALF
		: ebl_pkg::ENABLE_LOW_HALF; // see RULE15
	assign aligned = (size == ebl_pkg::EBL_SIZE_HALF) ? ~byte_addr[0]
		: (size == ebl_pkg::EBL_SIZE_WORD) ? (byte_addr == 2'h0)
		: (size == ebl_pkg::EBL_SIZE_BYTE); // see RULE9

	assign lane_enable = (size == ebl_pkg::EBL_SIZE_BYTE) ? byte_enable
		: (size == ebl_pkg::EBL_SIZE_HALF) ? half_enable
		: (size == ebl_pkg::EBL_SIZE_WORD) ? ebl_pkg::ENABLE_ALL
		: ebl_pkg::ENABLE_NONE; // see RULE19

	// four-way select from the generated lane
	assign mux4_out = bus_read_data[{byte_lane, 3'h0} +: 8]; // see RULE6
	// two-way select of lanes 0/1 or 2/3
	assign mux2_out = half_upper ? bus_read_data[31:16] : bus_read_data[15:0]; // see RULE8

	assign steered_read_data = (size == ebl_pkg::EBL_SIZE_BYTE) ? {24'h00_0000, mux4_out}
		: (size == ebl_pkg::EBL_SIZE_HALF) ? {16'h0000, mux2_out}
		: bus_read_data; // see RULE10

	// byte and halfword source bits from the low byte or halfword, other lanes copies; word passes through as is
	assign lane_write_data = (size == ebl_pkg::EBL_SIZE_BYTE) ? {4{store_value[7:0]}} // see RULE11
		: (size == ebl_pkg::EBL_SIZE_HALF) ? {2{store_value[15:0]}} // see RULE14
		: store_value; // see RULE17

endmodule

`default_nettype wire

// ### hw/ebl_top.sv
// Purpose: endian byte-lane steering between core load/store port and system bus
// Assumes: core_clk 125 MHz, one request at a time, bus answers with read valid
// Notes: no software-visible registers; control word is a plain input
//
// Contract
// RULE1: bus lanes wired straight to core lanes
// RULE2: no lane swapping for full-width transfers
// RULE3: control bit 7 picks order; indicated out
// RULE4: order bit applies regardless of MMU
// RULE5: byte read enables lane n or 3-n
// RULE6: four-way mux steers byte to byte 0
// RULE7: halfword read enable pairs swap when big-endian
// RULE8: two-way mux steers halfword into bytes 0-1
// RULE9: no halfword read at odd address
// RULE10: word read copies lanes straight through
// RULE11: byte write source is bits 7..0
// RULE12: byte write on lane n or 3-n
// RULE13: fabric ignores lanes with enables low
// RULE14: halfword write source is bits 15..0
// RULE15: halfword write at offset 2 lane placement
// RULE16: no halfword write at odd address
// RULE17: word write byte k on lane k, all enables
// RULE18: bits inside a byte stay 7..0
// RULE19: active-high enables held with address and data

`timescale 1ns/1ps
`default_nettype none

module ebl_top
(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// byte order control word
	input wire logic [31:0] sys_control,
	output logic big_endian_indication,
	// core request
	input wire logic core_req_valid,
	output logic core_req_ready,
	input wire logic core_req_write,
	input wire ebl_pkg::ebl_size_t core_req_size,
	input wire logic [31:0] core_req_addr,
	input wire logic [31:0] core_req_wdata,
	output logic core_req_error,
	// core read answer
	output logic core_rsp_valid,
	output logic [31:0] core_rsp_data,
	// system bus request
	output logic bus_valid,
	input wire logic bus_ready,
	output logic bus_write,
	output logic [31:0] bus_addr,
	output logic [31:0] bus_wdata,
	output logic [3:0] core_lane_enable,
	// system bus read answer
	input wire logic bus_rvalid,
	input wire logic [31:0] bus_rdata
);

	ebl_pkg::ebl_state_t state_q;
	ebl_pkg::ebl_state_t state_d;
	logic big_endian_q;
	logic bus_valid_q;
	logic bus_write_q;
	logic [31:0] bus_addr_q;
	logic [31:0] bus_wdata_q;
	logic [3:0] lane_enable_q;
	ebl_pkg::ebl_size_t rd_size_q;
	logic [1:0] rd_addr_q;
	logic rsp_valid_q;
	logic [31:0] rsp_data_q;
	logic error_q;
	logic rd_big_q;

	wire logic [3:0] req_enable;
	wire logic [31:0] req_wdata;
	wire logic req_aligned;
	wire logic [31:0] rd_steered;
	wire logic read_launch;
	wire logic issue_free;
	wire logic req_take;
	wire logic req_good;
	wire logic launch;
	wire logic read_done;

	// request-side steering
	ebl_lane_steer u_req_steer
	(
		.size(core_req_size),
		.byte_addr(core_req_addr[1:0]),
		.big_endian(big_endian_q),
		.store_value(core_req_wdata),
		.bus_read_data(32'h0000_0000),
		.lane_enable(req_enable),
		.lane_write_data(req_wdata),
		.steered_read_data(),
		.aligned(req_aligned)
	);

	// read-answer steering, using the captured access
	ebl_lane_steer u_rsp_steer
	(
		.size(rd_size_q),
		.byte_addr(rd_addr_q),
		.big_endian(rd_big_q),
		.store_value(32'h0000_0000),
		.bus_read_data(bus_rdata), // see RULE1
		.lane_enable(),
		.lane_write_data(),
		.steered_read_data(rd_steered),
		.aligned()
	);

	// handshake decode
	assign issue_free = (state_q == ebl_pkg::EBL_ST_IDLE) && (!bus_valid_q || bus_ready);
	assign core_req_ready = issue_free;
	assign req_take = clk_en && core_req_valid && issue_free;
	assign req_good = req_aligned; // see RULE9
	assign launch = req_take && req_good; // see RULE16
	assign read_launch = launch && !core_req_write;
	assign read_done = clk_en && (state_q == ebl_pkg::EBL_ST_READ_WAIT) && bus_rvalid;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ebl_pkg::EBL_ST_IDLE:
			begin
				if (read_launch)
				begin
					state_d = ebl_pkg::EBL_ST_READ_WAIT;
				end
			end
			ebl_pkg::EBL_ST_READ_WAIT:
			begin
				if (read_done)
				begin
					state_d = ebl_pkg::EBL_ST_IDLE;
				end
			end
		endcase
	end

	// byte order from control bit, no other qualifier
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			big_endian_q <= 1'b0;
		end
		else if (clk_en)
		begin
			big_endian_q <= sys_control[ebl_pkg::BIG_ENDIAN_BIT]; // see RULE3 see RULE4
		end
	end

	// bus request valid, held until taken
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bus_valid_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (launch)
			begin
				bus_valid_q <= 1'b1;
			end
			else if (bus_ready)
			begin
				bus_valid_q <= 1'b0;
			end
		end
	end

	// bus request payload, loaded only on launch
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bus_write_q <= 1'b0;
			bus_addr_q <= ebl_pkg::DATA_RESET;
			bus_wdata_q <= ebl_pkg::DATA_RESET;
			lane_enable_q <= ebl_pkg::ENABLE_NONE;
		end
		else if (clk_en && launch)
		begin
			bus_write_q <= core_req_write;
			bus_addr_q <= core_req_addr;
			bus_wdata_q <= req_wdata; // see RULE18
			lane_enable_q <= req_enable; // see RULE19
		end
	end

	// access state
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= ebl_pkg::EBL_ST_IDLE;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
		end
	end

	// one-cycle answer and error pulses
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rsp_valid_q <= 1'b0;
			error_q <= 1'b0;
		end
		else if (clk_en)
		begin
			rsp_valid_q <= read_done;
			error_q <= req_take && !req_good;
		end
	end

	// read context, order included, so a mid-read order change is harmless
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rd_size_q <= ebl_pkg::EBL_SIZE_WORD;
			rd_addr_q <= 2'h0;
			rd_big_q <= 1'b0;
		end
		else if (clk_en && read_launch)
		begin
			rd_size_q <= core_req_size;
			rd_addr_q <= core_req_addr[1:0];
			rd_big_q <= big_endian_q;
		end
	end

	// read answer data, held until the next read completes
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rsp_data_q <= ebl_pkg::DATA_RESET;
		end
		else if (clk_en && read_done)
		begin
			rsp_data_q <= rd_steered; // see RULE2 see RULE10
		end
	end

	assign big_endian_indication = big_endian_q; // see RULE3
	assign bus_valid = bus_valid_q;
	assign bus_write = bus_write_q;
	assign bus_addr = bus_addr_q;
	assign bus_wdata = bus_wdata_q;
	assign core_lane_enable = lane_enable_q; // see RULE13
	assign core_rsp_valid = rsp_valid_q;
	assign core_rsp_data = rsp_data_q;
	assign core_req_error = error_q;

endmodule

`default_nettype wire

// ### verification/ebl_sva.sv
// Purpose: ebl_top checks; Assumes: top ports only; Notes: bound by the bench
`timescale 1ns/1ps
`default_nettype none
module ebl_sva
(
	// watched ports
	input wire logic core_clk, rstn, clk_en, big_endian_indication, core_req_valid,
	input wire logic core_req_ready, core_req_write, core_req_error, core_rsp_valid,
	input wire logic bus_valid, bus_ready, bus_rvalid,
	input wire ebl_pkg::ebl_size_t core_req_size,
	input wire logic [3:0] core_lane_enable,
	input wire logic [31:0] sys_control, core_req_addr, bus_wdata, bus_addr
);
	logic [3:0] eq;
	wire logic [1:0] sz = core_req_size;
	wire logic [1:0] ad = core_req_addr[1:0];
	wire logic be = big_endian_indication;
	wire logic tk = clk_en && core_req_valid && core_req_ready;
	wire logic bad = sz == 2'h3 || (sz == 2'h1 && ad[0]) || (sz == 2'h2 && ad != 2'h0);
	wire logic drop = tk && bad;
	wire logic go = tk && !bad;
	wire logic [3:0] xe = sz == 2'h0 ? 4'h1 << (be ? 2'h3 - ad : ad)
		: sz == 2'h1 ? (ad[1] ^ be ? 4'hc : 4'h3) : 4'hf;
	always_ff @(posedge core_clk)
		if (tk)
			eq <= xe;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	order_ind_a: assert property
		(clk_en |=> be == $past(sys_control[7])) else $error("order indication");
	bad_drop_a: assert property
		(drop |=> core_req_error && !bus_valid) else $error("bad request");
	err_cause_a: assert property
		(core_req_error |-> $past(drop)) else $error("stray error");
	lane_en_a: assert property
		(go |=> bus_valid && core_lane_enable == eq) else $error("lane enables");
	req_hold_a: assert property
		(bus_valid && !bus_ready |=> $stable(core_lane_enable) && $stable(bus_wdata))
		else $error("request moved");
	bus_start_a: assert property
		($rose(bus_valid) |-> $past(go)) else $error("stray bus request");
	read_wait_a: assert property
		(go && !core_req_write |=> !core_req_ready) else $error("second read");
	rsp_src_a: assert property
		(core_rsp_valid |-> $past(bus_rvalid)) else $error("stray answer");
	bus_addr_a: assert property
		(go |=> bus_addr == $past(core_req_addr)) else $error("bus address");
endmodule
`default_nettype wire

// ### verification/ebl_bus_model.sv
// Purpose: far side with one memory word; Assumes: one request at a time; Notes: slow stalls
`timescale 1ns/1ps
`default_nettype none
module ebl_bus_model
(
	// bus side
	input wire logic core_clk, rstn, bus_valid, bus_write,
	input wire logic [1:0] slow,
	input wire logic [3:0] core_lane_enable,
	input wire logic [31:0] bus_wdata,
	output logic bus_ready,
	output logic bus_rvalid,
	output logic [31:0] bus_rdata
);
	logic [31:0] mem_q;
	logic [1:0] wait_q;
	assign bus_ready = bus_valid && wait_q == slow;
	assign bus_rdata = bus_rvalid ? mem_q : ~mem_q;
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			{mem_q, wait_q, bus_rvalid} <= '0;
		else
		begin
			wait_q <= bus_ready ? 2'h0 : wait_q + 2'(bus_valid);
			bus_rvalid <= bus_ready && !bus_write;
			for (int k = 0; k < 4; k++)
				if (bus_ready && bus_write && core_lane_enable[k])
					mem_q[8 * k +: 8] <= bus_wdata[8 * k +: 8];
		end
endmodule
`default_nettype wire

// ### verification/tb_ebl_top.sv
// Purpose: ebl_top bench; Assumes: model word on far side; Notes: one pass per order
`timescale 1ns/1ps
`default_nettype none
module tb_ebl_top;
	logic core_clk, rstn, clk_en, core_req_valid, core_req_write, big_endian_indication;
	logic core_req_ready, core_req_error, core_rsp_valid, bus_valid, bus_ready, bus_write;
	logic bus_rvalid;
	logic [1:0] slow;
	logic [3:0] core_lane_enable;
	logic [31:0] sys_control, core_req_addr, core_req_wdata, core_rsp_data, bus_addr;
	logic [31:0] bus_wdata, bus_rdata;
	ebl_pkg::ebl_size_t core_req_size;
	int errors = 0;
	int n_compared = 0;
	ebl_top dut_u (.*);
	ebl_bus_model mdl_u (.*);
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task check(input logic [31:0] s, e);
		n_compared++;
		errors += int'(s !== e);
		if (s !== e)
			$display("wrong value at %0t: %h not %h", $time, s, e);
	endtask
	task conclude;
		if (errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task acc(input logic w, input logic [1:0] s, a, input logic [31:0] d, output logic [31:0] r);
		@(negedge core_clk);
		{core_req_valid, core_req_write, core_req_addr, core_req_wdata} = {1'b1, w, 30'h0, a, d};
		core_req_size = ebl_pkg::ebl_size_t'(s);
		for (int i = 0; i < 50 && core_req_ready !== 1'b1; i++)
			@(negedge core_clk);
		@(negedge core_clk);
		core_req_valid = 1'b0;
		for (int i = 0; i < 50 && !w && core_req_error !== 1'b1 && core_rsp_valid !== 1'b1; i++)
			@(negedge core_clk);
		r = core_rsp_data;
	endtask
	task t_bytes(input logic b);
		logic [31:0] r, e;
		for (int n = 0; n < 4; n++)
		begin
			acc(1'b1, 2'h0, n[1:0], 32'h5500_00a0 + n, r);
			e[8 * (b ? 3 - n : n) +: 8] = 8'ha0 + 8'(n);
			acc(1'b0, 2'h0, n[1:0], 32'h0, r);
			check(r, 32'ha0 + n);
		end
		acc(1'b0, 2'h2, 2'h0, 32'h0, r);
		check(r, e);
	endtask
	task t_halves(input logic b);
		logic [31:0] r;
		acc(1'b1, 2'h1, 2'h0, 32'hffff_c1c0, r);
		acc(1'b1, 2'h1, 2'h2, 32'hffff_c3c2, r);
		acc(1'b0, 2'h2, 2'h0, 32'h0, r);
		check(r, b ? 32'hc1c0_c3c2 : 32'hc3c2_c1c0);
		acc(1'b0, 2'h1, 2'h2, 32'h0, r);
		check(r, 32'hc3c2);
		acc(1'b1, 2'h2, 2'h0, 32'h1234_5678, r);
		acc(1'b0, 2'h2, 2'h0, 32'h0, r);
		check(r, 32'h1234_5678);
	endtask
	task t_bad;
		logic [31:0] r;
		logic [29:0] c;
		c = {5'h1c, 5'h15, 5'h17, 5'h1a, 5'h05, 5'h0c};
		for (int k = 0; k < 6; k++)
		begin
			acc(c[5 * k + 4], c[5 * k + 2 +: 2], c[5 * k +: 2], 32'h0, r);
			check(core_req_error, 1'b1);
		end
	endtask
	task t_freeze;
		@(negedge core_clk);
		clk_en = 1'b0;
		sys_control[7] = !sys_control[7];
		core_req_valid = 1'b1;
		core_req_size = ebl_pkg::EBL_SIZE_BAD;
		repeat (3) @(negedge core_clk);
		check(big_endian_indication, !sys_control[7]);
		check(core_req_error, 1'b0);
		check(bus_valid, 1'b0);
		clk_en = 1'b1;
		core_req_valid = 1'b0;
		repeat (2) @(negedge core_clk);
		check(big_endian_indication, sys_control[7]);
		sys_control[7] = !sys_control[7];
		repeat (2) @(negedge core_clk);
	endtask
	initial
	begin
		{rstn, slow, sys_control, core_req_valid, core_req_write, core_req_addr, core_req_wdata} = '0;
		clk_en = 1'b1;
		core_req_size = ebl_pkg::EBL_SIZE_BYTE;
		repeat (5) @(negedge core_clk);
		rstn = 1'b1;
		for (int b = 0; b < 2; b++)
		begin
			sys_control[7] = b[0];
			slow = {b[0], 1'b0};
			repeat (2) @(negedge core_clk);
			check(big_endian_indication, b[0]);
			t_bytes(b[0]);
			t_halves(b[0]);
		end
		t_freeze;
		t_bad;
		conclude;
	end
	initial
	begin
		#100000;
		errors++;
		conclude;
	end
endmodule
bind ebl_top ebl_sva chk_u (.*);
`default_nettype wire
